// ### dfi_pkg.sv
/*
 * package for the decrement-memory-byte execute unit: opcode fields,
 * address map of the access bank, phase encoding, flag layout, reset values.
 * assumes a 16-bit program word and a 12-bit data address space.
 */
package dfi_pkg;

	// ------------------------------------------------------------------
	// instruction word
	// ------------------------------------------------------------------
	localparam logic [5:0]  DFI_OPC_DEC      = 6'h01;   // upper six bits 0000 01
	localparam int          DFI_OPC_POS      = 10;
	localparam int          DFI_DEST_POS     = 9;
	localparam int          DFI_ACC_POS      = 8;

	typedef struct packed {
		logic [5:0] opcode;
		logic       dest_file;   // 1: back to memory, 0: to working register
		logic       use_bank;    // 1: bank select register, 0: access bank
		logic [7:0] faddr;
	} dfi_instr_t;

	// ------------------------------------------------------------------
	// data address map
	// ------------------------------------------------------------------
	localparam logic [7:0]  DFI_ACC_SPLIT    = 8'h60;   // first sfr half of access bank
	localparam logic [7:0]  DFI_IDX_LAST     = 8'h5f;   // last indexed literal offset
	localparam logic [3:0]  DFI_ACC_HI_BANK  = 4'hf;
	localparam logic [3:0]  DFI_ACC_LO_BANK  = 4'h0;

	// ------------------------------------------------------------------
	// arithmetic and flags
	// ------------------------------------------------------------------
	localparam logic [7:0]  DFI_DEC_STEP     = 8'h01;
	localparam logic [7:0]  DFI_SIGN_MIN     = 8'h80;

	typedef struct packed {
		logic n;
		logic overflow_flag;
		logic z;
		logic half_carry_flag;
		logic c;
	} dfi_flags_t;

	localparam dfi_flags_t  DFI_FLAGS_RST    = '0;
	localparam logic [7:0]  DFI_W_RST        = 8'h00;
	localparam logic [3:0]  DFI_BANK_RST     = 4'h0;

	// ------------------------------------------------------------------
	// phases: four clocks make one instruction cycle
	// ------------------------------------------------------------------
	localparam int          DFI_CLK_NS       = 10;
	localparam int          DFI_CYCLE_CLKS   = 4;
	localparam int          DFI_CYCLE_NS     = DFI_CYCLE_CLKS * DFI_CLK_NS;

	typedef enum logic [1:0] {
		DFI_Q1 = 2'b00,
		DFI_Q2 = 2'b01,
		DFI_Q3 = 2'b10,
		DFI_Q4 = 2'b11
	} dfi_phase_t;

endpackage

// ### dfi_decrement_unit.sv
/*
 * decode and execute of the single-word decrement-memory-byte instruction
 * in a four-phase instruction cycle.
 * assumes a data memory on the same clock that answers a read one clock
 * after the read strobe, and that instr_word is held valid during phase one.
 */
// Summary of operation
// - read byte, subtract one, deliver result
// - match opcode, then d, a, 8-bit address
// - d clear: result to working register only
// - d set: result written back to memory
// - a clear: address inside shared access bank
// - a set: bank select register forms address
// - extended set, a clear, f<=95: indexed
// - update the five arithmetic flags only
// - one word, one cycle, write in phase four
`timescale 1ns/1ps
module dfi_decrement_unit
	import dfi_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic [15:0] instr_word,
	input  wire logic        instr_valid,
	input  wire logic        ext_set_en,
	input  wire logic [3:0]  bank_select_register,
	input  wire logic [11:0] index_base,
	input  wire logic [7:0]  mem_rdata,
	output logic      [11:0] mem_addr,
	output logic             mem_rd,
	output logic             mem_we,
	output logic      [7:0]  mem_wdata,
	output logic      [7:0]  w_reg,
	output dfi_flags_t       status_flags,
	output logic             flags_we,
	output dfi_phase_t       phase,
	output logic             busy
);

	// ------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------
	function automatic logic is_dec_op(input logic [15:0] word);
		is_dec_op = (word[15:DFI_OPC_POS] == DFI_OPC_DEC);
	endfunction

	// access bank splits into low general memory and high special registers
	function automatic logic [11:0] resolve_addr(
		input dfi_instr_t  ins,
		input logic [3:0]  bank,
		input logic        ext,
		input logic [11:0] base);
		if (ins.use_bank) begin
			resolve_addr = {bank, ins.faddr};
		end else if (ext && (ins.faddr <= DFI_IDX_LAST)) begin
			resolve_addr = 12'(base + {4'h0, ins.faddr});
		end else if (ins.faddr >= DFI_ACC_SPLIT) begin
			resolve_addr = {DFI_ACC_HI_BANK, ins.faddr};
		end else begin
			resolve_addr = {DFI_ACC_LO_BANK, ins.faddr};
		end
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	dfi_phase_t  phase_r,  phase_nxt;
	logic        act_r,    act_nxt;
	dfi_instr_t  ins_r,    ins_nxt;
	logic [11:0] addr_r,   addr_nxt;
	logic [7:0]  oper_r,   oper_nxt;
	logic [7:0]  res_r,    res_nxt;
	logic [7:0]  w_r,      w_nxt;
	dfi_flags_t  flags_r,  flags_nxt;
	dfi_flags_t  calc_r,   calc_nxt;

	dfi_instr_t  ins_in;
	assign ins_in = dfi_instr_t'(instr_word);

	always_comb begin
		phase_nxt = phase_r;
		act_nxt   = act_r;
		ins_nxt   = ins_r;
		addr_nxt  = addr_r;
		oper_nxt  = oper_r;
		res_nxt   = res_r;
		w_nxt     = w_r;
		flags_nxt = flags_r;
		calc_nxt  = calc_r;
		if (clk_en) begin
			case (phase_r)
				DFI_Q1: begin
					phase_nxt = DFI_Q2;
					// anything but the decrement leaves this unit idle
					act_nxt   = instr_valid && is_dec_op(instr_word);
					if (instr_valid && is_dec_op(instr_word)) begin
						ins_nxt  = ins_in;
						addr_nxt = resolve_addr(ins_in, bank_select_register,
						                        ext_set_en, index_base);
					end
				end
				DFI_Q2: begin
					phase_nxt = DFI_Q3;
				end
				DFI_Q3: begin
					phase_nxt = DFI_Q4;
					if (act_r) begin
						oper_nxt    = mem_rdata;
						res_nxt     = 8'(mem_rdata - DFI_DEC_STEP);
						calc_nxt.c  = (mem_rdata != 8'h00);
						calc_nxt.half_carry_flag = (mem_rdata[3:0] != 4'h0);
						calc_nxt.overflow_flag   = (mem_rdata == DFI_SIGN_MIN);
						calc_nxt.z  = (mem_rdata == DFI_DEC_STEP);
						calc_nxt.n  = res_nxt[7];
					end
				end
				DFI_Q4: begin
					phase_nxt = DFI_Q1;
					act_nxt   = 1'b0;
					if (act_r) begin
						flags_nxt = calc_r;
						if (!ins_r.dest_file) begin
							w_nxt = res_r;
						end
					end
				end
				default: begin
					phase_nxt = DFI_Q1;
					act_nxt   = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			phase_r <= DFI_Q1;
			act_r   <= 1'b0;
			ins_r   <= '0;
			addr_r  <= '0;
			oper_r  <= 8'h00;
			res_r   <= 8'h00;
			w_r     <= DFI_W_RST;
			flags_r <= DFI_FLAGS_RST;
			calc_r  <= DFI_FLAGS_RST;
		end else begin
			phase_r <= phase_nxt;
			act_r   <= act_nxt;
			ins_r   <= ins_nxt;
			addr_r  <= addr_nxt;
			oper_r  <= oper_nxt;
			res_r   <= res_nxt;
			w_r     <= w_nxt;
			flags_r <= flags_nxt;
			calc_r  <= calc_nxt;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// strobes are gated by clk_en so a frozen cycle never repeats an access
	assign mem_addr     = addr_r;
	assign mem_rd       = clk_en && act_r && (phase_r == DFI_Q2);
	assign mem_we       = clk_en && act_r && (phase_r == DFI_Q4) && ins_r.dest_file;
	assign mem_wdata    = res_r;
	assign flags_we     = clk_en && act_r && (phase_r == DFI_Q4);
	assign w_reg        = w_r;
	assign status_flags = flags_r;
	assign phase        = phase_r;
	assign busy         = act_r;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence s_exec_q4;
		clk_en && act_r && (phase_r == DFI_Q4);
	endsequence

	sequence s_read_q3;
		clk_en && act_r && (phase_r == DFI_Q3);
	endsequence

	phase_ring_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && (phase_r == DFI_Q1) |=> (phase_r == DFI_Q2))
		else $error("phase did not advance from one to two");

	decode_hit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && (phase_r == DFI_Q1) && instr_valid && is_dec_op(instr_word)
		|=> act_r && (ins_r == $past(ins_in)))
		else $error("decrement word not taken");

	decode_miss_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && (phase_r == DFI_Q1) && !(instr_valid && is_dec_op(instr_word))
		|=> !act_r)
		else $error("foreign word started the unit");

	dec_value_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_read_q3 |=> (res_r == 8'($past(mem_rdata) - DFI_DEC_STEP)))
		else $error("result is not operand minus one");

	w_dest_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_exec_q4 ##0 !ins_r.dest_file |-> !mem_we ##1 (w_r == $past(res_r)))
		else $error("working register not loaded");

	mem_dest_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_exec_q4 ##0 ins_r.dest_file |-> mem_we && (mem_wdata == res_r) ##1 $stable(w_r))
		else $error("memory write back missing");

	write_phase_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		mem_we |-> (phase_r == DFI_Q4) && act_r)
		else $error("memory written outside phase four");

	bank_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		act_r && (phase_r == DFI_Q2) && ins_r.use_bank
		|-> (mem_addr[7:0] == ins_r.faddr))
		else $error("banked address wrong");

	access_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && (phase_r == DFI_Q1) && instr_valid && is_dec_op(instr_word)
		&& !ins_in.use_bank && !ext_set_en
		|=> (mem_addr == {(ins_r.faddr >= DFI_ACC_SPLIT) ? DFI_ACC_HI_BANK
		                  : DFI_ACC_LO_BANK, ins_r.faddr}))
		else $error("access bank address wrong");

	index_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && (phase_r == DFI_Q1) && instr_valid && is_dec_op(instr_word)
		&& !ins_in.use_bank && ext_set_en && (ins_in.faddr <= DFI_IDX_LAST)
		|=> (mem_addr == 12'($past(index_base) + {4'h0, ins_r.faddr})))
		else $error("indexed address wrong");

	flags_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_exec_q4 |=> (flags_r.z == (res_r == 8'h00)) && (flags_r.n == res_r[7])
		&& (flags_r.c == (oper_r != 8'h00))
		&& (flags_r.half_carry_flag == (oper_r[3:0] != 4'h0))
		&& (flags_r.overflow_flag == (oper_r == DFI_SIGN_MIN)))
		else $error("status flags wrong after decrement");

	flags_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!flags_we |=> $stable(flags_r))
		else $error("flags changed without execute");

endmodule

// ### decrement_file_instruction_test.sv
/*
 * self-checking bench for the decrement-memory-byte execute unit.
 * assumes dfi_pkg and dfi_decrement_unit are compiled before this file.
 */
`timescale 1ns/1ps
module decrement_file_instruction_test import dfi_pkg::*;;
	logic        sys_clk;
	logic        sys_rst;
	logic        clk_en;
	logic [15:0] instr_word;
	logic        instr_valid;
	logic        ext_set_en;
	logic [3:0]  bank_select_register;
	logic [11:0] index_base;
	logic [7:0]  mem_rdata;
	logic [11:0] mem_addr;
	logic        mem_rd;
	logic        mem_we;
	logic [7:0]  mem_wdata;
	logic [7:0]  w_reg;
	dfi_flags_t  status_flags;
	logic        flags_we;
	dfi_phase_t  phase;
	logic        busy;
	int          failures;
	int          checks_done;

	dfi_decrement_unit i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.instr_word(instr_word), .instr_valid(instr_valid), .ext_set_en(ext_set_en),
		.bank_select_register(bank_select_register), .index_base(index_base),
		.mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_we(mem_we),
		.mem_wdata(mem_wdata), .w_reg(w_reg), .status_flags(status_flags),
		.flags_we(flags_we), .phase(phase), .busy(busy));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// one whole instruction cycle; optional clock-enable stall in Q3
	task automatic do_op(input logic [15:0] iw, input logic [7:0] opd, input logic [3:0] bk,
		input logic ext, input logic [11:0] base, input logic [11:0] ea, input logic stall);
		logic [7:0] res;
		logic [7:0] w_old;
		dfi_flags_t ef;
		res = opd - 8'h01;
		ef = '{n: res[7], overflow_flag: opd == 8'h80, z: res == 8'h00,
			half_carry_flag: opd[3:0] != 4'h0, c: opd != 8'h00};
		// phase is read before this edge's updates land, so Q4 means next is Q1
		do @(posedge sys_clk); while (phase !== DFI_Q4);
		instr_word <= iw;
		instr_valid <= 1'b1;
		bank_select_register <= bk;
		ext_set_en <= ext;
		index_base <= base;
		mem_rdata <= opd;
		// the edge ending phase one takes the word; the read strobe stands in phase two
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		#1;
		w_old = w_reg;
		chk("mem_rd", 12'h1, {11'h0, mem_rd});
		chk("mem_addr", ea, mem_addr);
		chk("busy", 12'h1, {11'h0, busy});
		@(posedge sys_clk);
		if (stall) begin
			clk_en <= 1'b0;
			repeat (3) @(posedge sys_clk);
			clk_en <= 1'b1;
			#1;
			chk("phase", {10'h0, DFI_Q3}, {10'h0, phase});
		end
		@(posedge sys_clk);
		#1;
		chk("mem_we", {11'h0, iw[DFI_DEST_POS]}, {11'h0, mem_we});
		chk("flags_we", 12'h1, {11'h0, flags_we});
		chk("mem_wdata", {4'h0, res}, {4'h0, mem_wdata});
		@(posedge sys_clk);
		#1;
		chk("w_reg", {4'h0, iw[DFI_DEST_POS] ? w_old : res}, {4'h0, w_reg});
		chk("flags", {7'h0, ef}, {7'h0, status_flags});
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_mem_bank();
		do_op(16'h0725, 8'h01, 4'h3, 1'b0, 12'h000, 12'h325, 1'b0);
	endtask

	task automatic t_wreg_access_hi();
		do_op(16'h0470, 8'h80, 4'h3, 1'b1, 12'h000, 12'hf70, 1'b1);
	endtask

	task automatic t_borrow_low();
		do_op(16'h0410, 8'h00, 4'h5, 1'b0, 12'h800, 12'h010, 1'b0);
	endtask

	task automatic t_indexed_edge();
		do_op(16'h065f, 8'h10, 4'h2, 1'b1, 12'hff0, 12'h04f, 1'b0);
		do_op(16'h0660, 8'h08, 4'h2, 1'b1, 12'hff0, 12'hf60, 1'b0);
	endtask

	task automatic t_refuse_other();
		logic [7:0] w_old;
		do @(posedge sys_clk); while (phase !== DFI_Q4);
		instr_word <= 16'h0b25;
		instr_valid <= 1'b1;
		#1;
		w_old = w_reg;
		repeat (8) begin
			@(posedge sys_clk);
			// second cycle offers a decrement word without its valid
			instr_word <= 16'h0725;
			instr_valid <= 1'b0;
			#1;
			chk("idle", 12'h0, {9'h0, busy, mem_rd, mem_we | flags_we});
		end
		chk("w_keep", {4'h0, w_old}, {4'h0, w_reg});
	endtask

	// ------------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		failures = 0;
		checks_done = 0;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		instr_word = 16'h0000;
		instr_valid = 1'b0;
		ext_set_en = 1'b0;
		bank_select_register = 4'h0;
		index_base = 12'h000;
		mem_rdata = 8'h00;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_mem_bank();
		t_wreg_access_hi();
		t_borrow_low();
		t_indexed_edge();
		t_refuse_other();
		print_verdict();
	end

	// all scenarios need well under 100 clocks
	initial begin
		#20000;
		failures++;
		print_verdict();
	end
endmodule
